// File: design/nfc_ctrl.sv
// How it works
// - Reads drive chip select and output gate low, write strobe high.
// - Command writes drive write strobe and chip select low, gate high.
// - Work cut off by a hardware reset is not reissued by the controller.
// - After reset release, wait the recovery time before reading.
// - On program or erase failure, write reset command to abort.
// - ID mode holds until reset command; controller always sends it.
// - Chip erase is six writes: unlock, 80h, unlock, 10h.
// - Sector for protect verify sits on address bits 19 to 12.
// - Unlock addresses 555h/2AAh in word mode, AAAh/555h in byte mode.
// - ID command is AAh, 55h, 90h at the unlock addresses.
`timescale 1ns/100ps
`default_nettype none

module nfc_ctrl #(
   parameter int RESET_SETTLE_CYC = nfc_pkg::RESET_SETTLE_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Flash control pins
   output logic      [19:0] flash_addr_o,
   output logic             chip_select_n_o,
   output logic             output_gate_n_o,
   output logic             write_strobe_n_o,
   output logic             hw_reset_n_o,
   input  wire logic        ready_busy_n_i,
   // Flash data pins, three signals each
   input  wire logic [15:0] flash_dq_i,
   output logic      [15:0] flash_dq_o,
   output logic             flash_dq_oe_n_o
);

   // Settle count must fit the 12-bit wait counter
   if (RESET_SETTLE_CYC < 1 || RESET_SETTLE_CYC > 4095) begin : g_bad_settle
      $error("RESET_SETTLE_CYC out of range");
   end

   // ----------------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0000,
      S_FETCH = 4'b0001,
      S_WSET  = 4'b0010,
      S_WPUL  = 4'b0011,
      S_WHLD  = 4'b0100,
      S_RACC  = 4'b0101,
      S_GAP   = 4'b0110,
      S_RSTL  = 4'b0111,
      S_RSTW  = 4'b1000
   } nfc_state_t;

   typedef enum logic [1:0] {
      K_WR = 2'b00, K_RD = 2'b01, K_POLL = 2'b10, K_END = 2'b11
   } nfc_kind_t;

   typedef enum logic [2:0] {
      A_UNL1 = 3'b000, A_UNL2 = 3'b001, A_USER = 3'b010,
      A_ID   = 3'b011, A_PV   = 3'b100
   } nfc_asel_t;

   nfc_state_t      state_ff;
   nfc_pkg::nfc_op_t op_ff;
   logic [2:0]      step_ff;
   logic [11:0]     cnt_ff;
   logic [19:0]     addr_ff;
   logic            byte_ff;
   logic [15:0]     rdata_ff;
   logic [15:0]     prev_ff;
   logic            have_prev_ff;
   logic            done_ff;
   logic            fail_ff;
   logic            start_ff;
   nfc_pkg::nfc_op_t req_op_ff;
   logic [15:0]     dq_sync;
   logic            rdy_sync;
   nfc_kind_t       kind;
   nfc_asel_t       asel;
   logic [7:0]      cdata;
   logic [19:0]     nxt_addr;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   nfc_sync #(.W(17)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({ready_busy_n_i, flash_dq_i}),
      .sync_o  ({rdy_sync, dq_sync})
   );

   // ----------------------------------------------------------------
   // Step table: what each step of an operation does
   // ----------------------------------------------------------------
   always_comb begin
      kind  = K_END;
      asel  = A_USER;
      cdata = nfc_pkg::CMD_RESET;
      unique case (op_ff)
         nfc_pkg::NFC_OP_READ: begin
            if (step_ff == 3'd0) kind = K_RD;
         end
         nfc_pkg::NFC_OP_RESET: begin
            if (step_ff == 3'd0) kind = K_WR;
         end
         nfc_pkg::NFC_OP_ID, nfc_pkg::NFC_OP_PV: begin
            unique case (step_ff)
               3'd0: begin
                  kind  = K_WR;
                  asel  = A_UNL1;
                  cdata = nfc_pkg::CMD_UNLOCK1;
               end
               3'd1: begin
                  kind  = K_WR;
                  asel  = A_UNL2;
                  cdata = nfc_pkg::CMD_UNLOCK2;
               end
               3'd2: begin
                  kind  = K_WR;
                  asel  = A_UNL1;
                  cdata = nfc_pkg::CMD_ID;
               end
               3'd3: begin
                  kind = K_RD;
                  asel = (op_ff == nfc_pkg::NFC_OP_ID) ? A_ID : A_PV;
               end
               3'd4: kind = K_WR;
               default: kind = K_END;
            endcase
         end
         nfc_pkg::NFC_OP_ERASE: begin
            kind = K_WR;
            unique case (step_ff)
               3'd0, 3'd3: begin
                  asel  = A_UNL1;
                  cdata = nfc_pkg::CMD_UNLOCK1;
               end
               3'd1, 3'd4: begin
                  asel  = A_UNL2;
                  cdata = nfc_pkg::CMD_UNLOCK2;
               end
               3'd2: begin
                  asel  = A_UNL1;
                  cdata = nfc_pkg::CMD_SETUP;
               end
               3'd5: begin
                  asel  = A_UNL1;
                  cdata = nfc_pkg::CMD_CHIP_ER;
               end
               3'd6: kind = K_POLL;
               default: kind = K_END;
            endcase
         end
         default: kind = K_END;
      endcase
   end

   // Address for the current step; unlock upper bits don't care, driven 0
   always_comb begin
      nxt_addr = addr_ff;
      unique case (asel)
         A_UNL1: nxt_addr = {8'h00, byte_ff ? nfc_pkg::UNL1_BYTE
                                            : nfc_pkg::UNL1_WORD};
         A_UNL2: nxt_addr = {8'h00, byte_ff ? nfc_pkg::UNL2_BYTE
                                            : nfc_pkg::UNL2_WORD};
         A_ID:   nxt_addr = {19'h00000, addr_ff[0]};
         A_PV:   nxt_addr = {addr_ff[19:12], 12'h002};
         default: nxt_addr = addr_ff;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer and pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff         <= S_IDLE;
         op_ff            <= nfc_pkg::NFC_OP_NONE;
         step_ff          <= 3'd0;
         cnt_ff           <= 12'h000;
         rdata_ff         <= nfc_pkg::RDATA_RESET;
         prev_ff          <= 16'h0000;
         have_prev_ff     <= 1'b0;
         done_ff          <= 1'b0;
         fail_ff          <= 1'b0;
         flash_addr_o     <= 20'h00000;
         chip_select_n_o  <= 1'b1;
         output_gate_n_o  <= 1'b1;
         write_strobe_n_o <= 1'b1;
         hw_reset_n_o     <= 1'b1;
         flash_dq_o       <= 16'h0000;
         flash_dq_oe_n_o  <= 1'b1;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               if (start_ff) begin
                  op_ff        <= req_op_ff;
                  step_ff      <= 3'd0;
                  done_ff      <= 1'b0;
                  fail_ff      <= 1'b0;
                  have_prev_ff <= 1'b0;
                  if (req_op_ff == nfc_pkg::NFC_OP_HWRST) begin
                     hw_reset_n_o <= 1'b0;
                     cnt_ff       <= 12'(nfc_pkg::RESET_PULSE_CYC);
                     state_ff     <= S_RSTL;
                  end else begin
                     state_ff <= S_FETCH;
                  end
               end
            end
            S_FETCH: begin
               flash_addr_o <= nxt_addr;
               unique case (kind)
                  K_WR: begin
                     chip_select_n_o <= 1'b0;
                     output_gate_n_o <= 1'b1;
                     flash_dq_o      <= {8'h00, cdata};
                     flash_dq_oe_n_o <= 1'b0;
                     state_ff        <= S_WSET;
                  end
                  K_RD, K_POLL: begin
                     chip_select_n_o <= 1'b0;
                     output_gate_n_o <= 1'b0;
                     flash_dq_oe_n_o <= 1'b1;
                     cnt_ff   <= 12'(nfc_pkg::ACCESS_CYC + 2);
                     state_ff <= S_RACC;
                  end
                  default: begin
                     done_ff  <= 1'b1;
                     state_ff <= S_IDLE;
                  end
               endcase
            end
            S_WSET: begin
               write_strobe_n_o <= 1'b0;
               cnt_ff           <= 12'(nfc_pkg::WE_LOW_CYC);
               state_ff         <= S_WPUL;
            end
            S_WPUL: begin
               if (cnt_ff <= 12'h001) begin
                  write_strobe_n_o <= 1'b1;
                  state_ff         <= S_WHLD;
               end else begin
                  cnt_ff <= cnt_ff - 12'h001;
               end
            end
            S_WHLD: begin
               chip_select_n_o <= 1'b1;
               flash_dq_oe_n_o <= 1'b1;
               step_ff         <= step_ff + 3'd1;
               state_ff        <= S_GAP;
            end
            S_RACC: begin
               if (cnt_ff <= 12'h001) begin
                  chip_select_n_o <= 1'b1;
                  output_gate_n_o <= 1'b1;
                  state_ff        <= S_GAP;
                  rdata_ff        <= dq_sync;
                  if (kind != K_POLL) begin
                     step_ff <= step_ff + 3'd1;
                  end else if (dq_sync[nfc_pkg::POLL_BIT] ||
                               (have_prev_ff &&
                                dq_sync[nfc_pkg::TOGGLE_BIT] ==
                                prev_ff[nfc_pkg::TOGGLE_BIT])) begin
                     step_ff <= step_ff + 3'd1;
                  end else if (dq_sync[nfc_pkg::TIMEOUT_BIT]) begin
                     fail_ff <= 1'b1;
                     op_ff   <= nfc_pkg::NFC_OP_RESET;
                     step_ff <= 3'd0;
                  end
                  prev_ff      <= dq_sync;
                  have_prev_ff <= 1'b1;
               end else begin
                  cnt_ff <= cnt_ff - 12'h001;
               end
            end
            S_GAP: state_ff <= S_FETCH;
            S_RSTL: begin
               if (cnt_ff <= 12'h001) begin
                  hw_reset_n_o <= 1'b1;
                  cnt_ff       <= 12'(RESET_SETTLE_CYC);
                  state_ff     <= S_RSTW;
               end else begin
                  cnt_ff <= cnt_ff - 12'h001;
               end
            end
            S_RSTW: begin
               // Wait for ready, then the recovery gap; bounded by settle
               if (rdy_sync && cnt_ff > 12'(nfc_pkg::RESET_RECOV_CYC)) begin
                  cnt_ff <= 12'(nfc_pkg::RESET_RECOV_CYC);
               end else if (cnt_ff <= 12'h001) begin
                  done_ff  <= 1'b1;
                  state_ff <= S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 12'h001;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Wishbone slave: ack one cycle after request, dropped next cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h00000000;
         addr_ff   <= nfc_pkg::ADDR_RESET;
         byte_ff   <= 1'b0;
         start_ff  <= 1'b0;
         req_op_ff <= nfc_pkg::NFC_OP_NONE;
      end else begin
         start_ff <= 1'b0;
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h00000000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i) begin
               unique case (wb_adr_i)
                  nfc_pkg::REG_CTRL: begin
                     // Start ignored while busy; op 0 only sets mode
                     if (wb_sel_i[1])
                        byte_ff <= wb_dat_i[nfc_pkg::CTRL_BYTE_BIT];
                     if (wb_sel_i[0] && state_ff == S_IDLE &&
                         wb_dat_i[2:0] != 3'b000) begin
                        start_ff  <= 1'b1;
                        req_op_ff <= nfc_pkg::nfc_op_t'(
                           wb_dat_i[nfc_pkg::CTRL_OP_LSB +: 3]);
                     end
                  end
                  nfc_pkg::REG_ADDR: begin
                     if (wb_sel_i[0]) addr_ff[7:0]   <= wb_dat_i[7:0];
                     if (wb_sel_i[1]) addr_ff[15:8]  <= wb_dat_i[15:8];
                     if (wb_sel_i[2]) addr_ff[19:16] <= wb_dat_i[19:16];
                  end
                  default: ;
               endcase
            end else begin
               unique case (wb_adr_i)
                  nfc_pkg::REG_CTRL:
                     wb_dat_o <= {23'h000000, byte_ff, 5'h00, op_ff};
                  nfc_pkg::REG_ADDR:   wb_dat_o <= {12'h000, addr_ff};
                  nfc_pkg::REG_STATUS: wb_dat_o <= {28'h0000000, rdy_sync,
                     fail_ff, done_ff, state_ff != S_IDLE || start_ff};
                  nfc_pkg::REG_RDATA:  wb_dat_o <= {16'h0000, rdata_ff};
                  default:             wb_dat_o <= 32'h00000000;
               endcase
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: design/nfc_pkg.sv
package nfc_pkg;

   // ----------------------------------------------------------------
   // Clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_NS        = 50;     // 20 MHz system clock
   localparam int RESET_PULSE_NS = 500;   // reset_pulse_min
   localparam int RESET_RECOV_NS = 50;    // reset_recovery_time
   localparam int RESET_SETTLE_NS = 20000; // reset_settle_time
   localparam int WE_LOW_NS     = 35;     // write strobe low time
   localparam int ACCESS_NS     = 70;     // read access time
   localparam int RESET_PULSE_CYC =
      (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_RECOV_CYC =
      (RESET_RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_SETTLE_CYC =
      (RESET_SETTLE_NS / CLK_NS) < 1 ? 1 : RESET_SETTLE_NS / CLK_NS;
   localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0c;
   localparam int CTRL_OP_LSB   = 0;      // op code, bits 2:0
   localparam int CTRL_BYTE_BIT = 8;      // byte mode unlock addresses
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_DONE_BIT   = 1;
   localparam int ST_FAIL_BIT   = 2;
   localparam int ST_RDY_BIT    = 3;
   localparam logic [19:0] ADDR_RESET  = 20'h00000;
   localparam logic [15:0] RDATA_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Operations that software can start
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      NFC_OP_NONE  = 3'b000,
      NFC_OP_READ  = 3'b001,
      NFC_OP_RESET = 3'b010,
      NFC_OP_ID    = 3'b011,
      NFC_OP_PV    = 3'b100,
      NFC_OP_ERASE = 3'b101,
      NFC_OP_HWRST = 3'b110
   } nfc_op_t;

   // ----------------------------------------------------------------
   // Command bytes and unlock addresses
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_UNLOCK1 = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0]  CMD_ID      = 8'h90;
   localparam logic [7:0]  CMD_SETUP   = 8'h80;
   localparam logic [7:0]  CMD_CHIP_ER = 8'h10;
   localparam logic [7:0]  CMD_RESET   = 8'hf0;
   localparam logic [11:0] UNL1_WORD   = 12'h555;
   localparam logic [11:0] UNL2_WORD   = 12'h2aa;
   localparam logic [11:0] UNL1_BYTE   = 12'haaa;
   localparam logic [11:0] UNL2_BYTE   = 12'h555;
   localparam int POLL_BIT    = 7;
   localparam int TOGGLE_BIT  = 6;
   localparam int TIMEOUT_BIT = 5;

endpackage

// File: design/nfc_sync.sv
`timescale 1ns/100ps
`default_nettype none

module nfc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Asynchronous level in, synchronised level out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;

   // Two stages; the first is read by the second only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_o  <= '0;
      end else begin
         meta_ff <= async_i;
         sync_o  <= meta_ff;
      end
   end

endmodule
`default_nettype wire

// File: verification/nfc_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none

module nfc_ctrl_chk (
   // Clock, reset and bus handshake
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic wb_cyc_i,
   input  wire logic wb_stb_i,
   input  wire logic wb_ack_o,
   // Flash strobes
   input  wire logic chip_select_n_o,
   input  wire logic output_gate_n_o,
   input  wire logic write_strobe_n_o,
   input  wire logic hw_reset_n_o,
   input  wire logic flash_dq_oe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Length of the reset pulse; saturates so a long pulse never wraps
   logic [7:0] rst_low_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i || hw_reset_n_o) begin
         rst_low_ff <= 8'h00;
      end else if (rst_low_ff != 8'hff) begin
         rst_low_ff <= rst_low_ff + 8'h01;
      end
   end

   // Write pulse end: strobe back up while selected, then deselect
   sequence s_write_tail;
      !chip_select_n_o ##1 (!chip_select_n_o && write_strobe_n_o)
         ##1 chip_select_n_o;
   endsequence

   a_ack_follows: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("bus request not acknowledged next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("acknowledge without request");
   a_read_levels: assert property (!output_gate_n_o |-> !chip_select_n_o && write_strobe_n_o)
      else $error("read strobes wrong");
   a_write_levels: assert property (!write_strobe_n_o |-> !chip_select_n_o && output_gate_n_o && !flash_dq_oe_n_o)
      else $error("write strobes wrong");
   a_no_contend: assert property (!flash_dq_oe_n_o |-> output_gate_n_o)
      else $error("data driven while flash outputs enabled");
   a_we_tail: assert property ($fell(write_strobe_n_o) |-> s_write_tail)
      else $error("write pulse shape wrong");
   a_reset_width: assert property ($rose(hw_reset_n_o) |-> rst_low_ff >= 8'(nfc_pkg::RESET_PULSE_CYC))
      else $error("reset pulse too short");
   a_reset_quiet: assert property (!hw_reset_n_o |-> chip_select_n_o)
      else $error("bus cycle during reset pulse");
   a_recov_gap: assert property ($rose(hw_reset_n_o) |-> output_gate_n_o ##1 output_gate_n_o)
      else $error("read too soon after reset");
endmodule

`default_nettype wire

// File: verification/nfc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none

module nfc_flash_model #(
   parameter logic [15:0] MAKER_CODE  = 16'h005a, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
   parameter logic [7:0]  PROT_SECTOR = 8'h3a,
   parameter int          ERASE_READS = 3
) (
   // Control pins
   input  wire logic [19:0] addr_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rst_n_i,
   // Controller data drive
   input  wire logic [15:0] dq_i,
   input  wire logic        dq_oe_n_i,
   // Test hooks
   input  wire logic        byte_mode_i,
   input  wire logic        erase_fail_i,
   // Wire level and ready/busy
   output logic      [15:0] dq_o,
   output logic             ready_busy_n_o
);
   logic [2:0]  step = 3'd0;
   logic        id_mode = 1'b0, erasing = 1'b0, erased = 1'b0, tog = 1'b0;
   logic        hit;
   logic [7:0]  d;
   logic [11:0] u1, u2;
   logic [15:0] rdata, last = 16'h0000;
   int          left = 0;

   // Unlock addresses follow the bus width
   assign u1 = byte_mode_i ? 12'haaa : 12'h555;
   assign u2 = byte_mode_i ? 12'h555 : 12'h2aa;
   assign ready_busy_n_o = !erasing;

   function automatic logic adr_ok(input logic [11:0] u);
      return byte_mode_i ? addr_i[11:0] == u : addr_i[10:0] == u[10:0];
   endfunction

   // Command decoder, latched as the write strobe rises
   always @(posedge we_n_i) begin
      if (!ce_n_i && rst_n_i) begin
         d = dq_o[7:0];
         hit = (step == 3'd1 || step == 3'd4) ? adr_ok(u2) && d == 8'h55 :
            adr_ok(u1) && d == (step == 3'd2 ? 8'h80 : step == 3'd5 ? 8'h10 : 8'haa);
         if (d == 8'hf0) begin
            step = 3'd0;
            id_mode = 1'b0;
            if (erase_fail_i) erasing = 1'b0;
         end else if (erasing) begin
            step = 3'd0;
         end else if (step == 3'd2 && adr_ok(u1) && d == 8'h90) begin
            id_mode = 1'b1;
            step = 3'd0;
         end else if (!hit) begin
            step = 3'd0;
         end else if (step == 3'd5) begin
            erasing = 1'b1;
            erased = 1'b1;
            left = ERASE_READS;
            tog = 1'b1;
            step = 3'd0;
         end else begin
            step = step + 3'd1;
         end
      end
   end

   // Hardware reset drops any sequence and job in progress
   always @(negedge rst_n_i) begin
      step = 3'd0;
      id_mode = 1'b0;
      erasing = 1'b0;
   end

   // Each status read moves the erase on; a failing erase ends only on a reset
   always @(posedge oe_n_i) begin
      if (erasing) begin
         tog = ~tog;
         if (left > 0) left--;
         if (left == 0 && !erase_fail_i) erasing = 1'b0;
      end
   end

   // What a read returns in each mode
   always @* begin
      if (id_mode) begin
         rdata = addr_i[1] ? {15'h0000, addr_i[19:12] == PROT_SECTOR} :
            addr_i[0] ? DEVICE_CODE : MAKER_CODE;
      end else if (erasing) begin
         rdata = {9'h000, tog, erase_fail_i && left == 0, 5'h00};
      end else if (erased) begin
         rdata = 16'hffff;
      end else begin
         rdata = addr_i[15:0] ^ 16'h6b29;
      end
   end

   // Undriven line shows the inverse of its last value, not a guess
   always @* begin
      if (!dq_oe_n_i) dq_o = dq_i;
      else if (!ce_n_i && !oe_n_i && rst_n_i) dq_o = rdata;
      else dq_o = ~last;
   end
   always @(dq_o) begin
      if (!dq_oe_n_i || (!ce_n_i && !oe_n_i && rst_n_i)) last = dq_o;
   end
endmodule

`default_nettype wire

// File: verification/tb_nfc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; $display("BAD %s exp %h got %h", nm, exp, got); end end

module tb_nfc_ctrl;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat_w = 32'h0, dat_r, q;
   logic        ack, ce_n, oe_n, we_n, hwr_n, rdy_n, dq_oe_n;
   logic        byte_mode = 1'b0, fail = 1'b0;
   logic [19:0] faddr;
   logic [15:0] dq_out, dq_line;
   int          mismatches = 0, compares = 0;

   always #25 clk_i = ~clk_i;
   nfc_ctrl #(.RESET_SETTLE_CYC(20)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .flash_addr_o(faddr),
      .chip_select_n_o(ce_n), .output_gate_n_o(oe_n),
      .write_strobe_n_o(we_n), .hw_reset_n_o(hwr_n),
      .ready_busy_n_i(rdy_n), .flash_dq_i(dq_line), .flash_dq_o(dq_out),
      .flash_dq_oe_n_o(dq_oe_n));

   nfc_flash_model u_flash (
      .addr_i(faddr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .rst_n_i(hwr_n), .dq_i(dq_out), .dq_oe_n_i(dq_oe_n),
      .byte_mode_i(byte_mode), .erase_fail_i(fail), .dq_o(dq_line),
      .ready_busy_n_o(rdy_n));

   // ------------------------------------------------------------
   // Bus and sequence tasks
   // ------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      `CHK(nm, exp, q)
   endtask

   task automatic start(input logic [31:0] c, input logic [19:0] a);
      wb(1'b1, nfc_pkg::REG_ADDR, {12'h000, a});
      wb(1'b1, nfc_pkg::REG_CTRL, c);
   endtask

   // Bounded poll of the done flag; a hang counts as a mismatch
   task automatic wait_done();
      int n = 0;
      do begin
         wb(1'b0, nfc_pkg::REG_STATUS, 32'h0);
         n++;
      end while (q[1] !== 1'b1 && n < 500);
      if (n >= 500) begin
         mismatches++;
         $display("BAD done exp 1 got %h", q);
      end
   endtask

   task automatic go(input logic [31:0] c, input logic [19:0] a);
      start(c, a);
      wait_done();
   endtask

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk("ctrl", nfc_pkg::REG_CTRL, 32'h0);
      rd_chk("addr", nfc_pkg::REG_ADDR, 32'h0);
      rd_chk("status", nfc_pkg::REG_STATUS, 32'h8);
      rd_chk("rdata", nfc_pkg::REG_RDATA, 32'h0);
      rd_chk("unmapped", 8'h20, 32'h0);
      $display("test reset_values done");
      go(32'h1, 20'h01234);
      rd_chk("array", nfc_pkg::REG_RDATA, 32'h791d);
      go(32'h3, 20'h00000);
      rd_chk("maker", nfc_pkg::REG_RDATA, 32'h005a);
      go(32'h3, 20'h00001);
      rd_chk("device", nfc_pkg::REG_RDATA, 32'h1234);
      byte_mode <= 1'b1;
      go(32'h103, 20'h00001);
      rd_chk("device_byte", nfc_pkg::REG_RDATA, 32'h1234);
      byte_mode <= 1'b0;
      go(32'h1, 20'h00abc);
      rd_chk("array_after_id", nfc_pkg::REG_RDATA, 32'h6195);
      $display("test id_mode done");
      go(32'h4, 20'h3a000);
      rd_chk("protected", nfc_pkg::REG_RDATA, 32'h1);
      go(32'h4, 20'h11000);
      rd_chk("unprotected", nfc_pkg::REG_RDATA, 32'h0);
      $display("test protect_verify done");
      // A start while busy must be dropped, so no ID code shows up
      start(32'h5, 20'h00000);
      start(32'h3, 20'h00000);
      wb(1'b0, nfc_pkg::REG_STATUS, 32'h0);
      `CHK("busy", 1'b1, q[0])
      wait_done();
      rd_chk("erase_status", nfc_pkg::REG_STATUS, 32'ha);
      rd_chk("poll_word", nfc_pkg::REG_RDATA, 32'hffff);
      go(32'h1, 20'h01234);
      rd_chk("erased", nfc_pkg::REG_RDATA, 32'hffff);
      $display("test chip_erase done");
      fail <= 1'b1;
      go(32'h5, 20'h00000);
      rd_chk("fail_status", nfc_pkg::REG_STATUS, 32'he);
      fail <= 1'b0;
      go(32'h1, 20'h01234);
      rd_chk("after_fail", nfc_pkg::REG_RDATA, 32'hffff);
      go(32'h2, 20'h00000);
      rd_chk("reset_cmd", nfc_pkg::REG_STATUS, 32'ha);
      $display("test erase_fail done");
      go(32'h6, 20'h00000);
      rd_chk("hwrst_status", nfc_pkg::REG_STATUS, 32'ha);
      go(32'h1, 20'h00abc);
      rd_chk("after_hwrst", nfc_pkg::REG_RDATA, 32'hffff);
      $display("test hw_reset done");
      tally_and_finish();
   end

   // Watchdog, far beyond the test length
   initial begin
      repeat (40000) @(posedge clk_i);
      mismatches++;
      $display("BAD watchdog exp finish got timeout");
      tally_and_finish();
   end
endmodule

bind nfc_ctrl nfc_ctrl_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .chip_select_n_o(chip_select_n_o), .output_gate_n_o(output_gate_n_o),
   .write_strobe_n_o(write_strobe_n_o), .hw_reset_n_o(hw_reset_n_o),
   .flash_dq_oe_n_o(flash_dq_oe_n_o));

`default_nettype wire
